/* File: inc/iosp_pkg.sv */
// iosp_pkg: offsets, field masks, access kinds and request/answer carriers of the i/o register space
package iosp_pkg;

    // address windows, data-space view; IOSP_BIT_IO_LAST and IOSP_PORT_IO_LAST in i/o view
    localparam logic [8:0] IOSP_IO_DATA_OFS = 9'h020;
    localparam logic [5:0] IOSP_BIT_IO_LAST = 6'h1F;
    localparam logic [5:0] IOSP_PORT_IO_LAST = 6'h3F;
    localparam logic [8:0] IOSP_EXT_FIRST = 9'h060;
    localparam logic [8:0] IOSP_EXT_LAST = 9'h1FF;
    localparam logic [8:0] IOSP_REG_FIRST = 9'h020;
    localparam logic [8:0] IOSP_REG_LAST = 9'h051;
    localparam int IOSP_NREG = 50;
    localparam int IOSP_NPORT = 7;
    localparam int IOSP_NFLAG = 8;
    localparam int IOSP_FLAG_FIRST_IDX = 21;
    localparam logic [7:0] IOSP_RESET_VAL = 8'h00;

    // register offsets, data-space addresses
    localparam logic [8:0] PORT_A_PIN_INPUT = 9'h020;
    localparam logic [8:0] PORT_A_DIRECTION = 9'h021;
    localparam logic [8:0] PORT_A_OUTPUT = 9'h022;
    localparam logic [8:0] PORT_B_PIN_INPUT = 9'h023;
    localparam logic [8:0] PORT_B_DIRECTION = 9'h024;
    localparam logic [8:0] PORT_B_OUTPUT = 9'h025;
    localparam logic [8:0] PORT_C_PIN_INPUT = 9'h026;
    localparam logic [8:0] PORT_C_DIRECTION = 9'h027;
    localparam logic [8:0] PORT_C_OUTPUT = 9'h028;
    localparam logic [8:0] PORT_D_PIN_INPUT = 9'h029;
    localparam logic [8:0] PORT_D_DIRECTION = 9'h02A;
    localparam logic [8:0] PORT_D_OUTPUT = 9'h02B;
    localparam logic [8:0] PORT_E_PIN_INPUT = 9'h02C;
    localparam logic [8:0] PORT_E_DIRECTION = 9'h02D;
    localparam logic [8:0] PORT_E_OUTPUT = 9'h02E;
    localparam logic [8:0] PORT_F_PIN_INPUT = 9'h02F;
    localparam logic [8:0] PORT_F_DIRECTION = 9'h030;
    localparam logic [8:0] PORT_F_OUTPUT = 9'h031;
    localparam logic [8:0] PORT_G_PIN_INPUT = 9'h032;
    localparam logic [8:0] PORT_G_DIRECTION = 9'h033;
    localparam logic [8:0] PORT_G_OUTPUT = 9'h034;
    localparam logic [8:0] TIMER0_EVENT_FLAGS = 9'h035;
    localparam logic [8:0] TIMER1_EVENT_FLAGS = 9'h036;
    localparam logic [8:0] TIMER2_EVENT_FLAGS = 9'h037;
    localparam logic [8:0] TIMER3_EVENT_FLAGS = 9'h038;
    localparam logic [8:0] TIMER4_EVENT_FLAGS = 9'h039;
    localparam logic [8:0] TIMER5_EVENT_FLAGS = 9'h03A;
    localparam logic [8:0] PIN_CHANGE_IRQ_FLAGS = 9'h03B;
    localparam logic [8:0] EXTERNAL_IRQ_FLAGS = 9'h03C;
    localparam logic [8:0] EXTERNAL_IRQ_MASK = 9'h03D;
    localparam logic [8:0] GENERAL_SCRATCH_0 = 9'h03E;
    localparam logic [8:0] EEPROM_CONTROL = 9'h03F;
    localparam logic [8:0] EEPROM_DATA_BYTE = 9'h040;
    localparam logic [8:0] EEPROM_ADDRESS_LOW = 9'h041;
    localparam logic [8:0] EEPROM_ADDRESS_HIGH = 9'h042;
    localparam logic [8:0] TIMER_PRESCALER_CONTROL = 9'h043;
    localparam logic [8:0] TIMER0_CONTROL_A = 9'h044;
    localparam logic [8:0] TIMER0_CONTROL_B = 9'h045;
    localparam logic [8:0] TIMER0_COUNT = 9'h046;
    localparam logic [8:0] TIMER0_COMPARE_A = 9'h047;
    localparam logic [8:0] TIMER0_COMPARE_B = 9'h048;
    localparam logic [8:0] GENERAL_SCRATCH_1 = 9'h04A;
    localparam logic [8:0] GENERAL_SCRATCH_2 = 9'h04B;
    localparam logic [8:0] SERIAL_PERIPH_CONTROL = 9'h04C;
    localparam logic [8:0] SERIAL_PERIPH_STATE = 9'h04D;
    localparam logic [8:0] SERIAL_PERIPH_SHIFT_DATA = 9'h04E;
    localparam logic [8:0] COMPARATOR_CONTROL_STATE = 9'h050;
    localparam logic [8:0] DEBUG_DATA_CHANNEL = 9'h051;

    // implemented-bit masks; reserved bits read zero
    localparam logic [7:0] MASK_FULL = 8'hFF;
    localparam logic [7:0] MASK_PORT_G = 8'h3F;
    localparam logic [7:0] MASK_TIMER_8BIT_FLAGS = 8'h07;
    localparam logic [7:0] MASK_TIMER_16BIT_FLAGS = 8'h2F;
    localparam logic [7:0] MASK_PIN_CHANGE_FLAGS = 8'h07;
    localparam logic [7:0] MASK_EEPROM_CONTROL = 8'h3F;
    localparam logic [7:0] MASK_EEPROM_ADDR_HIGH = 8'h0F;
    localparam logic [7:0] MASK_PRESCALER = 8'h83;
    localparam logic [7:0] MASK_TIMER0_CTRL_A = 8'hF3;
    localparam logic [7:0] MASK_TIMER0_CTRL_B = 8'hCF;
    localparam logic [7:0] MASK_SERIAL_STATE = 8'hC1;

    typedef enum logic [1:0] {
        K_RES = 2'b00,
        K_RW = 2'b01,
        K_W1C = 2'b10,
        K_PIN = 2'b11
    } iosp_kind_e;

    // direct and displaced loads/stores arrive as data_load_op / data_store_op
    typedef enum logic [2:0] {
        OP_IO_IN = 3'b000,
        OP_IO_OUT = 3'b001,
        SET_IO_BIT_OP = 3'b010,
        CLEAR_IO_BIT_OP = 3'b011,
        SKIP_IF_IO_BIT_ONE_OP = 3'b100,
        SKIP_IF_IO_BIT_ZERO_OP = 3'b101,
        DATA_LOAD_OP = 3'b110,
        DATA_STORE_OP = 3'b111
    } iosp_op_e;

    typedef struct packed {
        logic valid;
        iosp_op_e op;
        logic [8:0] addr;
        logic [7:0] wdata;
        logic [2:0] bit_sel;
    } iosp_req_s;

    typedef struct packed {
        logic ack;
        logic refused;
        logic skip;
        logic [7:0] rdata;
    } iosp_rsp_s;

    function automatic iosp_kind_e iosp_kind(input logic [8:0] a);
        iosp_kind_e k;
        k = K_RW;
        if (a < IOSP_REG_FIRST || a > IOSP_REG_LAST || a == 9'h049 || a == 9'h04F) begin
            k = K_RES;
        end else if (a >= TIMER0_EVENT_FLAGS && a <= EXTERNAL_IRQ_FLAGS) begin
            k = K_W1C;
        end else if (a <= PORT_G_OUTPUT && ((a - IOSP_REG_FIRST) % 3) == 0) begin
            k = K_PIN;
        end
        return k;
    endfunction : iosp_kind

    function automatic logic [7:0] iosp_mask(input logic [8:0] a);
        logic [7:0] m;
        m = MASK_FULL;
        if (iosp_kind(a) == K_RES) begin
            m = 8'h00;
        end else if (a >= PORT_G_PIN_INPUT && a <= PORT_G_OUTPUT) begin
            m = MASK_PORT_G;
        end else if (a == TIMER0_EVENT_FLAGS || a == TIMER2_EVENT_FLAGS) begin
            m = MASK_TIMER_8BIT_FLAGS;
        end else if (a == TIMER1_EVENT_FLAGS || (a >= TIMER3_EVENT_FLAGS && a <= TIMER5_EVENT_FLAGS)) begin
            m = MASK_TIMER_16BIT_FLAGS;
        end else if (a == PIN_CHANGE_IRQ_FLAGS) begin
            m = MASK_PIN_CHANGE_FLAGS;
        end else if (a == EEPROM_CONTROL) begin
            m = MASK_EEPROM_CONTROL;
        end else if (a == EEPROM_ADDRESS_HIGH) begin
            m = MASK_EEPROM_ADDR_HIGH;
        end else if (a == TIMER_PRESCALER_CONTROL) begin
            m = MASK_PRESCALER;
        end else if (a == TIMER0_CONTROL_A) begin
            m = MASK_TIMER0_CTRL_A;
        end else if (a == TIMER0_CONTROL_B) begin
            m = MASK_TIMER0_CTRL_B;
        end else if (a == SERIAL_PERIPH_STATE) begin
            m = MASK_SERIAL_STATE;
        end
        return m;
    endfunction : iosp_mask

endpackage : iosp_pkg

/* File: core/iosp_regbank.sv */
// iosp_regbank: i/o register space decoder and storage as the processor core sees it
//
// Contract
// - set, clear and bit-skip operations reach only i/o locations 0x00 to 0x1F.
// - flag bits marked write-one-to-clear clear on a written one; zero leaves them.
// - set/clear bit ops rewrite the whole register, so set flags get cleared, all but the bit a clear op names.
// - port in/out instructions address i/o locations 0x00 to 0x3F, 64 places.
// - data-space accesses find each i/o register at its i/o address plus 0x20.
// - extended region 0x60 to 0x1FF is reachable only by data loads and stores.
`timescale 1ns/1ps
module iosp_regbank
    import iosp_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // core access, one request per valid cycle
    input wire iosp_req_s req,
    output iosp_rsp_s rsp,
    // peripheral events, one bit per flag, pulse or level
    input wire logic [IOSP_NFLAG-1:0][7:0] flag_set,
    // port pins, asynchronous to clk
    input wire logic [IOSP_NPORT-1:0][7:0] pin_in,
    // register image towards the peripherals
    output logic [IOSP_NPORT-1:0][7:0] port_dir,
    output logic [IOSP_NPORT-1:0][7:0] port_out,
    output logic [IOSP_NREG-1:0][7:0] reg_image
);

    logic [7:0] regs_q [IOSP_NREG];
    logic [IOSP_NPORT-1:0][7:0] pin_meta_q;
    logic [IOSP_NPORT-1:0][7:0] pin_sync_q;
    logic [8:0] daddr;
    logic [8:0] doffs;
    logic [5:0] idx;
    logic legal;
    logic hit;
    logic is_write;
    logic [7:0] cur;
    logic [7:0] onehot;
    logic [7:0] wr_val;
    logic wr_en;
    iosp_rsp_s rsp_q;

    // pins pass two flops before anything reads them
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pin_meta_q <= '0;
            pin_sync_q <= '0;
        end else begin
            pin_meta_q <= pin_in;
            pin_sync_q <= pin_meta_q;
        end
    end

    // address forming per instruction class
    always_comb begin
        daddr = 9'h000;
        legal = 1'b0;
        is_write = 1'b0;
        unique case (req.op)
            OP_IO_IN, OP_IO_OUT: begin
                // six-bit opcode field: only 64 places, extended region out of reach
                legal = (req.addr[8:6] == 3'b000);
                daddr = {3'b000, req.addr[5:0]} + IOSP_IO_DATA_OFS;
                is_write = (req.op == OP_IO_OUT);
            end
            SET_IO_BIT_OP, CLEAR_IO_BIT_OP, SKIP_IF_IO_BIT_ONE_OP, SKIP_IF_IO_BIT_ZERO_OP: begin
                legal = (req.addr[8:6] == 3'b000) && (req.addr[5:0] <= IOSP_BIT_IO_LAST);
                daddr = {3'b000, req.addr[5:0]} + IOSP_IO_DATA_OFS;
                is_write = (req.op == SET_IO_BIT_OP) || (req.op == CLEAR_IO_BIT_OP);
            end
            DATA_LOAD_OP, DATA_STORE_OP: begin
                // full nine-bit address reaches the extended region too
                legal = 1'b1;
                daddr = req.addr;
                is_write = (req.op == DATA_STORE_OP);
            end
        endcase
    end

    assign doffs = daddr - IOSP_REG_FIRST;
    assign idx = doffs[5:0];
    assign hit = legal && (daddr >= IOSP_REG_FIRST) && (daddr <= IOSP_REG_LAST)
        && (iosp_kind(daddr) != K_RES);
    assign onehot = 8'h01 << req.bit_sel;

    // current value as the core sees it; unmapped places read zero
    always_comb begin
        cur = 8'h00;
        if (hit) begin
            cur = regs_q[idx];
        end
    end

    // bit ops read the whole register and write it all back
    always_comb begin
        wr_val = req.wdata;
        if (req.op == SET_IO_BIT_OP) begin
            wr_val = cur | onehot;
        end else if (req.op == CLEAR_IO_BIT_OP) begin
            wr_val = cur & ~onehot;
        end
    end

    assign wr_en = req.valid && hit && is_write;

    // storage, one entry per location; masks keep reserved bits at zero
    for (genvar i = 0; i < IOSP_NREG; i++) begin : g_reg
        localparam logic [8:0] ADDR = IOSP_REG_FIRST + 9'(i);
        localparam iosp_kind_e KIND = iosp_kind(ADDR);
        localparam logic [7:0] MASK = iosp_mask(ADDR);
        if (KIND == K_RW) begin : g_rw
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    regs_q[i] <= IOSP_RESET_VAL;
                end else if (wr_en && idx == 6'(i)) begin
                    regs_q[i] <= wr_val & MASK;
                end
            end
        end else if (KIND == K_W1C) begin : g_w1c
            logic [7:0] clr;
            assign clr = (wr_en && idx == 6'(i)) ? wr_val : 8'h00;
            // an event in the clearing cycle survives: set wins
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    regs_q[i] <= IOSP_RESET_VAL;
                end else begin
                    regs_q[i] <= ((regs_q[i] & ~clr) | flag_set[i - IOSP_FLAG_FIRST_IDX]) & MASK;
                end
            end
        end else if (KIND == K_PIN) begin : g_pin
            // writes are dropped here; pin state costs one extra cycle of latency
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    regs_q[i] <= IOSP_RESET_VAL;
                end else begin
                    regs_q[i] <= pin_sync_q[i / 3] & MASK;
                end
            end
        end else begin : g_res
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    regs_q[i] <= IOSP_RESET_VAL;
                end else begin
                    regs_q[i] <= IOSP_RESET_VAL;
                end
            end
        end
        assign reg_image[i] = regs_q[i];
    end

    for (genvar p = 0; p < IOSP_NPORT; p++) begin : g_port
        assign port_dir[p] = regs_q[3 * p + 1];
        assign port_out[p] = regs_q[3 * p + 2];
    end

    // answer one cycle after the request
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rsp_q <= '0;
        end else begin
            rsp_q.ack <= req.valid;
            rsp_q.refused <= req.valid && !legal;
            rsp_q.rdata <= req.valid ? cur : 8'h00;
            rsp_q.skip <= req.valid && legal
                && (((req.op == SKIP_IF_IO_BIT_ONE_OP) && cur[req.bit_sel])
                || ((req.op == SKIP_IF_IO_BIT_ZERO_OP) && !cur[req.bit_sel]));
        end
    end

    assign rsp = rsp_q;

endmodule : iosp_regbank

/* File: tb/iosp_regbank_sva.sv */
// iosp_regbank_sva: port-level checks of the i/o register bank
`timescale 1ns/1ps
module iosp_regbank_sva
    import iosp_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // core side
    input wire iosp_req_s req,
    input wire iosp_rsp_s rsp,
    // peripheral side
    input wire logic [IOSP_NFLAG-1:0][7:0] flag_set,
    input wire logic [IOSP_NPORT-1:0][7:0] pin_in,
    input wire logic [IOSP_NPORT-1:0][7:0] port_dir,
    input wire logic [IOSP_NPORT-1:0][7:0] port_out,
    input wire logic [IOSP_NREG-1:0][7:0] reg_image
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    logic bitop;
    logic io_op;
    assign bitop = req.valid && req.op inside {SET_IO_BIT_OP, CLEAR_IO_BIT_OP,
        SKIP_IF_IO_BIT_ONE_OP, SKIP_IF_IO_BIT_ZERO_OP};
    assign io_op = req.valid && req.op inside {OP_IO_IN, OP_IO_OUT};
    property p_ack;
        req.valid |=> rsp.ack;
    endproperty
    a_ack: assert property (p_ack) else $error("no answer to a request");
    property p_bitref;
        bitop && req.addr > 9'h01F |=> rsp.ack && rsp.refused && !rsp.skip;
    endproperty
    a_bitref: assert property (p_bitref) else $error("high bit op taken");
    property p_bitok;
        bitop && req.addr <= 9'h01F |=> !rsp.refused;
    endproperty
    a_bitok: assert property (p_bitok) else $error("low bit op refused");
    property p_ioref;
        io_op && req.addr[8:6] != 3'h0 |=> rsp.refused && rsp.rdata == 8'h00;
    endproperty
    a_ioref: assert property (p_ioref) else $error("port op beyond 0x3F");
    property p_map;
        io_op && req.op == OP_IO_OUT && req.addr == 9'h001 |=> port_dir[0] == $past(req.wdata);
    endproperty
    a_map: assert property (p_map) else $error("port write misplaced");
    property p_w1c;
        req.valid && req.op == DATA_STORE_OP && req.addr == TIMER0_EVENT_FLAGS
            && flag_set[0] == 8'h00 |=> reg_image[21] == ($past(reg_image[21]) & ~$past(req.wdata));
    endproperty
    a_w1c: assert property (p_w1c) else $error("flag clear wrong");
    property p_rmw;
        req.valid && req.op == SET_IO_BIT_OP && req.addr == 9'h015
            && flag_set[0] == 8'h00 |=> reg_image[21] == 8'h00;
    endproperty
    a_rmw: assert property (p_rmw) else $error("set bit left flags");
    property p_skip;
        req.valid && req.op == SKIP_IF_IO_BIT_ONE_OP && req.addr == 9'h015
            |=> rsp.skip == $past(reg_image[21][req.bit_sel]);
    endproperty
    a_skip: assert property (p_skip) else $error("skip wrong");
    property p_resv;
        req.valid && req.op == DATA_LOAD_OP && (req.addr == 9'h049 || req.addr > IOSP_REG_LAST)
            |=> rsp.rdata == 8'h00;
    endproperty
    a_resv: assert property (p_resv) else $error("reserved read nonzero");
endmodule : iosp_regbank_sva

bind iosp_regbank iosp_regbank_sva CHK (.clk(clk), .resetn(resetn), .req(req), .rsp(rsp),
    .flag_set(flag_set), .pin_in(pin_in), .port_dir(port_dir), .port_out(port_out),
    .reg_image(reg_image));

/* File: tb/iosp_core_model.sv */
// iosp_core_model: processor side, one access at a time
`timescale 1ns/1ps
module iosp_core_model
    import iosp_pkg::*;
(
    // clock
    input wire logic clk,
    // access channel
    output iosp_req_s req,
    input wire iosp_rsp_s rsp
);
    initial req = '0;
    // reserved places are written only where the bench means it
    task automatic access(input iosp_op_e op, input logic [8:0] a, input logic [7:0] wd,
        input logic [2:0] b, output iosp_rsp_s r);
        @(posedge clk);
        #1 req = {1'b1, op, a, wd, b};
        @(posedge clk);
        #1 r = rsp;
        // idle fields inverted so a stale address cannot pass unseen
        req = {1'b0, op, ~a, ~wd, ~b};
    endtask : access
endmodule : iosp_core_model

/* File: tb/iosp_regbank_tb.sv */
// iosp_regbank_tb: directed access sequences against the i/o register bank
`timescale 1ns/1ps
module iosp_regbank_tb;
    import iosp_pkg::*;
    logic clk;
    logic resetn;
    iosp_req_s req;
    iosp_rsp_s rsp;
    logic [IOSP_NFLAG-1:0][7:0] flag_set;
    logic [IOSP_NPORT-1:0][7:0] pin_in;
    logic [IOSP_NPORT-1:0][7:0] port_dir;
    logic [IOSP_NPORT-1:0][7:0] port_out;
    logic [IOSP_NREG-1:0][7:0] reg_image;
    int err_total;
    int samples_checked;
    iosp_rsp_s r;
    logic [7:0] e;

    iosp_core_model CORE (.clk(clk), .req(req), .rsp(rsp));
    iosp_regbank DUT (.clk(clk), .resetn(resetn), .req(req), .rsp(rsp), .flag_set(flag_set),
        .pin_in(pin_in), .port_dir(port_dir), .port_out(port_out), .reg_image(reg_image));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic chk(input string n, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", n, exp, got);
        end
    endtask : chk

    // data is compared only where the op reads or is refused; refusals always answer zero
    task automatic acc(input iosp_op_e op, input logic [8:0] a, input logic [7:0] wd,
        input logic [2:0] b, input logic [7:0] exp, input logic rf, input logic sk);
        CORE.access(op, a, wd, b, r);
        chk("ack", 8'h01, {7'h00, r.ack});
        chk("refused", {7'h00, rf}, {7'h00, r.refused});
        if (rf || op inside {OP_IO_IN, DATA_LOAD_OP}) chk("rdata", exp, r.rdata);
        if (rf || op inside {SKIP_IF_IO_BIT_ONE_OP, SKIP_IF_IO_BIT_ZERO_OP}) begin
            chk("skip", {7'h00, sk}, {7'h00, r.skip});
        end
    endtask : acc

    task automatic ld(input logic [8:0] a, input logic [7:0] exp);
        acc(DATA_LOAD_OP, a, 8'h00, 3'h0, exp, 1'b0, 1'b0);
    endtask : ld

    task automatic st(input logic [8:0] a, input logic [7:0] wd);
        acc(DATA_STORE_OP, a, wd, 3'h0, 8'h00, 1'b0, 1'b0);
    endtask : st

    task automatic pulse(input logic [7:0] v);
        @(posedge clk);
        // every flag register sees the same event, so a mix-up in the event-to-register mapping goes unseen
        #1 flag_set = {IOSP_NFLAG{v}};
        @(posedge clk);
        #1 flag_set = '0;
    endtask : pulse

    task automatic conclude;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : conclude

    initial begin
        err_total = 0;
        samples_checked = 0;
        resetn = 1'b0;
        flag_set = '0;
        pin_in = '0;
        repeat (16) @(posedge clk);
        #1 resetn = 1'b1;
        for (int a = 'h20; a <= 'h53; a++) ld(a[8:0], 8'h00);
        for (int p = 0; p < IOSP_NPORT; p++) begin
            e = (p == 6) ? 8'h25 : 8'hA5;
            acc(OP_IO_OUT, 9'(3 * p + 1), 8'hA5, 3'h0, 8'h00, 1'b0, 1'b0);
            acc(OP_IO_OUT, 9'(3 * p + 2), 8'h5A, 3'h0, 8'h00, 1'b0, 1'b0);
            ld(9'(3 * p + 'h21), e);
            ld(9'(3 * p + 'h22), ~e & ((p == 6) ? 8'h3F : 8'hFF));
            chk("port_dir", e, port_dir[p]);
            chk("port_out", ~e & ((p == 6) ? 8'h3F : 8'hFF), port_out[p]);
        end
        acc(SET_IO_BIT_OP, 9'h001, 8'h00, 3'h6, 8'h00, 1'b0, 1'b0);
        acc(CLEAR_IO_BIT_OP, 9'h001, 8'h00, 3'h0, 8'h00, 1'b0, 1'b0);
        acc(OP_IO_IN, 9'h001, 8'h00, 3'h0, 8'hE4, 1'b0, 1'b0);
        for (int k = 2; k < 6; k++) acc(iosp_op_e'(k), 9'h020, 8'h00, 3'h0, 8'h00, 1'b1, 1'b0);
        acc(OP_IO_IN, 9'h040, 8'h00, 3'h0, 8'h00, 1'b1, 1'b0);
        acc(OP_IO_OUT, 9'h060, 8'hFF, 3'h0, 8'h00, 1'b1, 1'b0);
        acc(OP_IO_IN, 9'h03F, 8'h00, 3'h0, 8'h00, 1'b0, 1'b0);
        st(9'h060, 8'hFF);
        ld(9'h060, 8'h00);
        st(9'h049, 8'hFF);
        ld(9'h049, 8'h00);
        st(9'h042, 8'hFF);
        ld(9'h042, 8'h0F);
        pulse(8'hFF);
        ld(9'h035, 8'h07);
        ld(9'h036, 8'h2F);
        ld(9'h03C, 8'hFF);
        acc(OP_IO_OUT, 9'h01C, 8'hF0, 3'h0, 8'h00, 1'b0, 1'b0);
        ld(9'h03C, 8'h0F);
        st(9'h035, 8'h02);
        st(9'h035, 8'h00);
        ld(9'h035, 8'h05);
        acc(SKIP_IF_IO_BIT_ONE_OP, 9'h015, 8'h00, 3'h0, 8'h00, 1'b0, 1'b1);
        acc(SKIP_IF_IO_BIT_ZERO_OP, 9'h015, 8'h00, 3'h1, 8'h00, 1'b0, 1'b1);
        acc(CLEAR_IO_BIT_OP, 9'h015, 8'h00, 3'h0, 8'h00, 1'b0, 1'b0);
        ld(9'h035, 8'h01);
        pulse(8'h07);
        acc(SET_IO_BIT_OP, 9'h015, 8'h00, 3'h1, 8'h00, 1'b0, 1'b0);
        ld(9'h035, 8'h00);
        pin_in[1] = 8'hC3;
        repeat (6) @(posedge clk);
        st(9'h023, 8'h00);
        acc(OP_IO_IN, 9'h003, 8'h00, 3'h0, 8'hC3, 1'b0, 1'b0);
        acc(SKIP_IF_IO_BIT_ZERO_OP, 9'h003, 8'h00, 3'h2, 8'h00, 1'b0, 1'b1);
        conclude();
    end

    // the sequence needs well under 1000 cycles; three times that means a hang
    initial begin
        #(3000 * 100);
        err_total++;
        conclude();
    end
endmodule : iosp_regbank_tb
